/* logic/spx_master.sv */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - only this master drives the serial clock line.
// - every transfer is started by the master, on a write of data byte 3.
// - MISO is data in to the master, MOSI is data out from it.
// - four separate chip-select outputs address up to four peripherals.
// - the peripheral interrupt line is an input of the master.
// - software picks the serial clock between 1 MHz and about 6.7 MHz.
// - the serial clock is an integer division of the bus clock.
// - all four clock modes come from idle level and sample edge.
// - control bit 7 sets the clock idle level, 0 low and 1 high.
// - control bit 6 picks the sample edge, 0 rising and 1 falling.
// - control bits 5-4 set the frame length, 00 8 bits, 01 16 bits.
// - control bit 3 picks automatic (0) or software (1) chip select.
// - control bits 2-0 pick the select, 000 none, 001-100 selects 0-3.
module spx_master (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [13:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_sclk,
  output logic             o_mosi,
  input  wire logic        i_miso,
  output logic             o_peripheral_select_0_n,
  output logic             o_peripheral_select_1_n,
  output logic             o_peripheral_select_2_n,
  output logic             o_peripheral_select_3_n,
  input  wire logic        i_peripheral_irq_n,
  output logic             o_irq
);

  typedef struct packed {
    spx_pkg::spx_state_type st;
    logic [7:0]  ctrl;
    logic [7:0]  half;
    logic [31:0] tx;
    logic [31:0] rx;
    logic [6:0]  edges;
    logic        sclk;
    logic        mosi;
    logic [3:0]  cs_n;
    logic [1:0]  ev;
    logic [1:0]  mask;
    logic        irq;
    logic        pirq_prev;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } spx_master_type;

  spx_master_type s_q;
  spx_master_type s_d;

  logic        miso_s;
  logic        pirq_n_s;
  logic        tick;
  logic        access;
  logic        wr;
  logic        hit;
  logic [11:0] idx;
  logic [31:0] rdata;
  logic [1:0]  len;
  logic [2:0]  sel;
  logic        sel_ok;
  logic        busy;
  logic        sample;
  logic        pirq;
  logic [1:0]  ev_set;
  logic [1:0]  ev_clr;
  logic [7:0]  wbyte;

  // ****************************************
  // pin inputs
  // ****************************************
  spx_sync #(.RST_VAL(1'b0)) u_miso_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_miso),
    .o_sync  (miso_s)
  );

  spx_sync #(.RST_VAL(1'b1)) u_pirq_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_peripheral_irq_n),
    .o_sync  (pirq_n_s)
  );

  spx_tick #(.W(8)) u_tick (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_run  (s_q.st != spx_pkg::ST_IDLE),
    .i_half (s_q.half),
    .o_tick (tick)
  );

  // ****************************************
  // register read mux
  // ****************************************
  assign idx    = i_paddr[13:2];
  assign access = i_psel & i_penable;
  assign wr     = access & s_q.pready & i_pwrite & ~s_q.pslverr;
  assign len    = s_q.ctrl[spx_pkg::CTRL_LEN_LSB +: 2];
  assign sel    = s_q.ctrl[spx_pkg::CTRL_SEL_LSB +: 3];
  assign sel_ok = (sel != spx_pkg::SEL_NONE) && (sel <= spx_pkg::SEL_LAST);
  assign busy   = s_q.st != spx_pkg::ST_IDLE;
  assign pirq   = ~pirq_n_s;
  assign wbyte  = i_pwdata[7:0];

  always_comb begin
    hit   = i_paddr[1:0] == 2'h0;
    rdata = 32'h0;
    unique case (idx)
      spx_pkg::CTRL_IDX:  rdata[7:0] = s_q.ctrl;
      spx_pkg::STAT_IDX: begin
        rdata[spx_pkg::ST_BUSY_BIT] = busy;
        rdata[spx_pkg::ST_IRQ_BIT]  = pirq;
      end
      spx_pkg::DATA0_IDX: rdata[7:0] = s_q.rx[7:0];
      spx_pkg::DATA1_IDX: rdata[7:0] = s_q.rx[15:8];
      spx_pkg::DATA2_IDX: rdata[7:0] = s_q.rx[23:16];
      spx_pkg::DATA3_IDX: rdata[7:0] = s_q.rx[31:24];
      spx_pkg::ISTAT_IDX: rdata[1:0] = s_q.ev;
      spx_pkg::IMASK_IDX: rdata[1:0] = s_q.mask;
      spx_pkg::DIV_IDX:   rdata[7:0] = s_q.half;
      default:            hit = 1'b0;
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d    = s_q;
    ev_set = 2'h0;
    ev_clr = 2'h0;
    sample = 1'b0;

    // apb: one wait state, answer registered
    s_d.pready  = access & ~s_q.pready;
    s_d.pslverr = access & ~s_q.pready & ~hit;
    if (access && !s_q.pready) begin
      s_d.prdata = hit ? rdata : 32'h0;
    end

    // writes; control and data locked while busy
    if (wr) begin
      unique case (idx)
        spx_pkg::CTRL_IDX: begin
          if (!busy) begin
            s_d.ctrl = wbyte;
          end
        end
        spx_pkg::DATA0_IDX: begin
          if (!busy) begin
            s_d.tx[7:0] = wbyte;
          end
        end
        spx_pkg::DATA1_IDX: begin
          if (!busy) begin
            s_d.tx[15:8] = wbyte;
          end
        end
        spx_pkg::DATA2_IDX: begin
          if (!busy) begin
            s_d.tx[23:16] = wbyte;
          end
        end
        spx_pkg::DATA3_IDX: begin
          if (!busy) begin
            s_d.tx[31:24] = wbyte;
            // start only with a valid select
            if (sel_ok) begin
              s_d.st    = spx_pkg::ST_LEAD;
              s_d.edges = 7'h00;
              s_d.mosi  = wbyte[7];
            end
          end
        end
        spx_pkg::ISTAT_IDX: ev_clr = i_pwdata[1:0];
        spx_pkg::IMASK_IDX: s_d.mask = i_pwdata[1:0];
        spx_pkg::DIV_IDX: begin
          if (wbyte < spx_pkg::HALF_MIN) begin
            s_d.half = spx_pkg::HALF_MIN;
          end else if (wbyte > spx_pkg::HALF_MAX) begin
            s_d.half = spx_pkg::HALF_MAX;
          end else begin
            s_d.half = wbyte;
          end
        end
        default: ;
      endcase
    end

    // serial engine
    unique case (s_q.st)
      spx_pkg::ST_IDLE: begin
        s_d.sclk = s_d.ctrl[spx_pkg::CTRL_POL_BIT];
      end
      spx_pkg::ST_LEAD: begin
        if (tick) begin
          s_d.st = spx_pkg::ST_RUN;
        end
      end
      spx_pkg::ST_RUN: begin
        if (tick) begin
          s_d.sclk  = ~s_q.sclk;
          s_d.edges = s_q.edges + 7'h01;
          // sample when the new level matches the chosen edge
          sample = s_d.sclk == ~s_q.ctrl[spx_pkg::CTRL_EDGE_BIT];
          if (sample) begin
            s_d.rx = {s_q.rx[30:0], miso_s};
          end else if (s_q.edges != 7'h00) begin
            s_d.tx   = {s_q.tx[30:0], 1'b0};
            s_d.mosi = s_q.tx[30];
          end
          if (s_d.edges == {3'(len) + 3'h1, 4'h0}) begin
            s_d.st = spx_pkg::ST_TAIL;
          end
        end
      end
      spx_pkg::ST_TAIL: begin
        if (tick) begin
          s_d.st = spx_pkg::ST_IDLE;
          ev_set[spx_pkg::EV_DONE_BIT] = 1'b1;
          // align the received frame to the most significant bits
          unique case (spx_pkg::spx_len_type'(len))
            spx_pkg::LEN_8:  s_d.rx = {s_q.rx[7:0], 24'h0};
            spx_pkg::LEN_16: s_d.rx = {s_q.rx[15:0], 16'h0};
            spx_pkg::LEN_24: s_d.rx = {s_q.rx[23:0], 8'h0};
            spx_pkg::LEN_32: s_d.rx = s_q.rx;
          endcase
        end
      end
    endcase

    // chip selects from next state
    s_d.cs_n = 4'hF;
    if (s_d.ctrl[spx_pkg::CTRL_SEL_LSB +: 3] != spx_pkg::SEL_NONE &&
        s_d.ctrl[spx_pkg::CTRL_SEL_LSB +: 3] <= spx_pkg::SEL_LAST &&
        (s_d.ctrl[spx_pkg::CTRL_MAN_BIT] ||
         s_d.st != spx_pkg::ST_IDLE)) begin
      s_d.cs_n = ~(4'h1 << (s_d.ctrl[1:0] - 2'h1));
    end

    // peripheral interrupt event, set wins over clear
    s_d.pirq_prev = pirq;
    ev_set[spx_pkg::EV_PIRQ_BIT] = pirq & ~s_q.pirq_prev;
    s_d.ev  = (s_q.ev & ~ev_clr) | ev_set;
    s_d.irq = |(s_d.ev & s_d.mask);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q      <= '0;
      s_q.st   <= spx_pkg::ST_IDLE;
      s_q.ctrl <= spx_pkg::CTRL_RST;
      s_q.half <= spx_pkg::DIV_RST;
      s_q.cs_n <= 4'hF;
      s_q.ev   <= spx_pkg::EV_RST;
      s_q.mask <= spx_pkg::EV_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_prdata  = s_q.prdata;
  assign o_pready  = s_q.pready;
  assign o_pslverr = s_q.pslverr;
  assign o_sclk    = s_q.sclk;
  assign o_mosi    = s_q.mosi;
  assign o_irq     = s_q.irq;
  assign o_peripheral_select_0_n = s_q.cs_n[0];
  assign o_peripheral_select_1_n = s_q.cs_n[1];
  assign o_peripheral_select_2_n = s_q.cs_n[2];
  assign o_peripheral_select_3_n = s_q.cs_n[3];

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_sclk_idle_level:
    assert property (s_q.st == spx_pkg::ST_IDLE
      |-> o_sclk == s_q.ctrl[spx_pkg::CTRL_POL_BIT])
    else $error("serial clock not at idle level");

  a_no_start_off:
    assert property (s_q.st == spx_pkg::ST_IDLE && !sel_ok
      |=> s_q.st == spx_pkg::ST_IDLE)
    else $error("transfer started without a select");

  a_cs_one_hot:
    assert property ($onehot0(~s_q.cs_n))
    else $error("more than one chip select low");

  a_cs_off_none:
    assert property (sel == spx_pkg::SEL_NONE |-> s_q.cs_n == 4'hF)
    else $error("chip select low with port disabled");

  a_cs_auto_idle:
    assert property (!s_q.ctrl[spx_pkg::CTRL_MAN_BIT]
      && s_q.st == spx_pkg::ST_IDLE |-> s_q.cs_n == 4'hF)
    else $error("automatic select low while idle");

  a_sclk_in_frame:
    assert property (o_sclk != s_q.ctrl[spx_pkg::CTRL_POL_BIT]
      |-> s_q.st == spx_pkg::ST_RUN && s_q.cs_n != 4'hF)
    else $error("clock active outside a selected frame");

  a_mosi_at_sample:
    assert property (s_q.st == spx_pkg::ST_RUN && $changed(o_sclk)
      && o_sclk != s_q.ctrl[spx_pkg::CTRL_EDGE_BIT] |-> $stable(o_mosi))
    else $error("data out moved on a sample edge");

  a_frame_edges:
    assert property ($rose(s_q.st == spx_pkg::ST_TAIL)
      |-> s_q.edges == {3'(len) + 3'h1, 4'h0})
    else $error("wrong number of clock edges in frame");

  a_div_range:
    assert property (s_q.half >= spx_pkg::HALF_MIN
      && s_q.half <= spx_pkg::HALF_MAX)
    else $error("clock divider out of range");

  a_pirq_flag:
    assert property (pirq && !s_q.pirq_prev
      |=> s_q.ev[spx_pkg::EV_PIRQ_BIT] ##1 o_irq || !s_q.mask[1])
    else $error("peripheral interrupt not flagged");

  c_frame_32: cover property ($rose(s_q.st == spx_pkg::ST_TAIL)
    && len == 2'h3);
  c_mode_3: cover property ($rose(s_q.st == spx_pkg::ST_TAIL)
    && s_q.ctrl[7:6] == 2'h3);
  c_manual: cover property ($rose(s_q.st == spx_pkg::ST_RUN)
    && s_q.ctrl[spx_pkg::CTRL_MAN_BIT]);
  c_pirq: cover property ($rose(s_q.ev[spx_pkg::EV_PIRQ_BIT]));

endmodule

`default_nettype wire

/* logic/spx_pkg.sv */
package spx_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ      = 40_000_000;
  localparam int SCLK_MIN_HZ = 1_000_000;
  localparam int SCLK_MAX_HZ = 8_000_000;
  // half periods of the serial clock, in bus clock cycles
  localparam int HALF_MIN_INT =
    (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
  localparam int HALF_MAX_INT = CLK_HZ / (2 * SCLK_MIN_HZ);
  localparam logic [7:0] HALF_MIN = 8'(HALF_MIN_INT);
  localparam logic [7:0] HALF_MAX = 8'(HALF_MAX_INT);

  // ****************************************
  // register indices, byte address = index * 4
  // ****************************************
  localparam logic [11:0] CTRL_IDX  = 12'hCA8;
  localparam logic [11:0] STAT_IDX  = 12'hCA9;
  localparam logic [11:0] DATA0_IDX = 12'hCAA;
  localparam logic [11:0] DATA1_IDX = 12'hCAB;
  localparam logic [11:0] DATA2_IDX = 12'hCAC;
  localparam logic [11:0] DATA3_IDX = 12'hCAD;
  localparam logic [11:0] ISTAT_IDX = 12'hCB0;
  localparam logic [11:0] IMASK_IDX = 12'hCB1;
  localparam logic [11:0] DIV_IDX   = 12'hCB2;

  // ****************************************
  // fields
  // ****************************************
  localparam int CTRL_POL_BIT  = 7;
  localparam int CTRL_EDGE_BIT = 6;
  localparam int CTRL_LEN_LSB  = 4;
  localparam int CTRL_MAN_BIT  = 3;
  localparam int CTRL_SEL_LSB  = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DIV_RST  = HALF_MAX;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_IRQ_BIT  = 1;
  localparam int EV_DONE_BIT = 0;
  localparam int EV_PIRQ_BIT = 1;
  localparam logic [1:0] EV_RST = 2'h0;
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_LAST = 3'h4;

  typedef enum logic [1:0] {
    LEN_8, LEN_16, LEN_24, LEN_32
  } spx_len_type;

  typedef enum logic [1:0] {
    ST_IDLE, ST_LEAD, ST_RUN, ST_TAIL
  } spx_state_type;

endpackage

/* logic/spx_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// two-flop synchroniser
// ****************************************
module spx_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_async,
  output logic      o_sync
);

  typedef struct packed {
    logic meta;
    logic sync;
  } spx_sync_type;

  spx_sync_type s_q;
  spx_sync_type s_d;

  always_comb begin
    s_d.meta = i_async;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '{meta: RST_VAL, sync: RST_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_sync = s_q.sync;

endmodule

`default_nettype wire

/* logic/spx_tick.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// half-period tick generator
// ****************************************
module spx_tick #(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_run,
  input  wire logic [W-1:0] i_half,
  output logic              o_tick
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } spx_tick_type;

  spx_tick_type s_q;
  spx_tick_type s_d;

  // one pulse every i_half cycles while running
  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (!i_run) begin
      s_d.cnt = '0;
    end else if (s_q.cnt >= i_half - W'(1)) begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + W'(1);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_tick = s_q.tick;

endmodule

`default_nettype wire

/* verification/sme_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// behavioural peripheral on the port
// ****************************************
module sme_slave_model (
  input  wire logic        i_sclk,
  input  wire logic        i_mosi,
  input  wire logic        i_cs_n,
  input  wire logic        i_sample_fall,
  input  wire logic [31:0] i_tx,
  input  wire logic        i_irq_req,
  output logic             o_miso,
  output logic             o_irq_n,
  output logic      [31:0] o_rx
);
  logic [31:0] tx_q;
  int          nsamp;

  initial begin
    o_miso = 1'b0;
    o_rx = 32'h0;
    nsamp = 0;
  end

  assign o_irq_n = !i_irq_req;

  always @(negedge i_cs_n) begin
    tx_q = i_tx;
    nsamp = 0;
    o_rx = 32'h0;
    o_miso = i_tx[31];
  end

  // never shifts before the first sample edge
  always @(i_sclk) begin
    if (i_cs_n === 1'b0 && i_sclk === !i_sample_fall) begin
      o_rx = {o_rx[30:0], i_mosi};
      nsamp++;
    end else if (i_cs_n === 1'b0 && nsamp > 0) begin
      tx_q = tx_q << 1;
      o_miso = tx_q[31];
    end
  end

  // released line shows no stale value
  always @(posedge i_cs_n) o_miso = ~o_miso;
endmodule

`default_nettype wire

/* verification/test_spi_master_expansion.sv */
`timescale 1ns/1ps
`default_nettype none

module test_spi_master_expansion;
  logic        clk, rst, psel, pen, pwr, pready, pslverr, perr;
  logic        sclk, mosi, miso, irq, irq_n, irq_req, fall, sclk_p;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd, stx, srx;
  logic [3:0]  sel_n, seen;
  int          errors = 0, samples_checked = 0;
  int          edges, gap, last_gap, div;

  spx_master uut (
    .i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_sclk(sclk), .o_mosi(mosi), .i_miso(miso),
    .o_peripheral_select_0_n(sel_n[0]), .o_peripheral_select_1_n(sel_n[1]),
    .o_peripheral_select_2_n(sel_n[2]), .o_peripheral_select_3_n(sel_n[3]),
    .i_peripheral_irq_n(irq_n), .o_irq(irq)
  );

  sme_slave_model partner (
    .i_sclk(sclk), .i_mosi(mosi), .i_cs_n(&sel_n),
    .i_sample_fall(fall), .i_tx(stx), .i_irq_req(irq_req),
    .o_miso(miso), .o_irq_n(irq_n), .o_rx(srx)
  );

  // ****************************************
  // clock and link monitor
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (sel_n !== 4'hF) begin
      seen = seen | ~sel_n;
      if (sclk !== sclk_p) begin
        edges++;
        last_gap = gap;
        gap = 1;
      end else gap++;
    end
    sclk_p = sclk;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] idx,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdr(input logic [11:0] idx);
    apb(1'b0, idx, 32'h0);
  endtask

  task automatic end_sim;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    chk("selects", 32'hF, 32'(sel_n));
    chk("sclk idle", 32'h0, 32'(sclk));
    rdr(spx_pkg::CTRL_IDX);
    chk("ctrl", 32'(spx_pkg::CTRL_RST), rd);
    rdr(spx_pkg::DIV_IDX);
    chk("div", 32'(spx_pkg::DIV_RST), rd);
    rdr(spx_pkg::ISTAT_IDX);
    chk("istat", 32'h0, rd);
    apb(1'b0, 12'hFFF, 32'h0);
    chk("pslverr", 32'h1, 32'(perr));
  endtask

  task automatic frame(input logic [7:0] c, input logic [31:0] tx);
    int          nb, n;
    logic [31:0] r;
    nb = 8 * (int'(c[5:4]) + 1);
    fall = c[6];
    wr(spx_pkg::CTRL_IDX, {24'h0, c});
    for (int i = 0; i < 3; i++)
      wr(spx_pkg::DATA0_IDX + 12'(i), {24'h0, tx[8*i +: 8]});
    edges = 0;
    seen = 4'h0;
    wr(spx_pkg::DATA3_IDX, {24'h0, tx[31:24]});
    n = 0;
    while (irq !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    chk("done irq", 32'h1, 32'(irq));
    chk("sclk edges", 32'(2 * nb), 32'(edges));
    chk("half period", 32'(div), 32'(last_gap));
    chk("select used", 32'(4'h1 << (c[2:0] - 3'h1)), 32'(seen));
    chk("select end", 32'hF, 32'(sel_n));
    chk("idle level", 32'(c[7]), 32'(sclk));
    chk("slave rx", tx >> (32 - nb), srx);
    for (int i = 0; i < 4; i++) begin
      rdr(spx_pkg::DATA0_IDX + 12'(i));
      r[8*i +: 8] = rd[7:0];
    end
    chk("master rx", (stx >> (32 - nb)) << (32 - nb), r);
    wr(spx_pkg::ISTAT_IDX, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq clear", 32'h0, 32'(irq));
  endtask

  task automatic t_frames;
    wr(spx_pkg::DIV_IDX, 32'h1);
    rdr(spx_pkg::DIV_IDX);
    chk("div min", 32'(spx_pkg::HALF_MIN), rd);
    wr(spx_pkg::DIV_IDX, 32'hC8);
    rdr(spx_pkg::DIV_IDX);
    chk("div max", 32'(spx_pkg::HALF_MAX), rd);
    wr(spx_pkg::IMASK_IDX, 32'h1);
    div = 20;
    frame(8'h31, 32'h9B2D_E817);
    div = 4;
    wr(spx_pkg::DIV_IDX, 32'h4);
    for (int m = 0; m < 4; m++)
      for (int l = 0; l < 4; l++)
        frame({2'(m), 2'(l), 1'b0, 3'(1 + (m + l) % 4)},
              32'h9B2D_E817 ^ {4{8'(m * 4 + l)}});
  endtask

  task automatic t_refused;
    logic [2:0] codes [4];
    codes = '{3'h0, 3'h5, 3'h6, 3'h7};
    foreach (codes[i]) begin
      wr(spx_pkg::CTRL_IDX, {29'h0, codes[i]});
      seen = 4'h0;
      wr(spx_pkg::DATA3_IDX, 32'hFF);
      repeat (10) @(posedge clk);
      rdr(spx_pkg::STAT_IDX);
      chk("busy", 32'h0, 32'(rd[0]));
      chk("no select", 32'h0, 32'(seen));
    end
  endtask

  task automatic t_manual;
    wr(spx_pkg::CTRL_IDX, 32'h0A);
    repeat (2) @(posedge clk);
    chk("manual 1", 32'hD, 32'(sel_n));
    wr(spx_pkg::CTRL_IDX, 32'h0C);
    repeat (2) @(posedge clk);
    chk("manual 3", 32'h7, 32'(sel_n));
    wr(spx_pkg::CTRL_IDX, 32'h08);
    repeat (2) @(posedge clk);
    chk("manual none", 32'hF, 32'(sel_n));
  endtask

  task automatic t_pirq;
    wr(spx_pkg::IMASK_IDX, 32'h2);
    irq_req <= 1'b1;
    repeat (6) @(posedge clk);
    chk("pirq out", 32'h1, 32'(irq));
    rdr(spx_pkg::STAT_IDX);
    chk("pirq level", 32'h1, 32'(rd[1]));
    irq_req <= 1'b0;
    wr(spx_pkg::ISTAT_IDX, 32'h2);
    repeat (2) @(posedge clk);
    chk("pirq clear", 32'h0, 32'(irq));
    wr(spx_pkg::IMASK_IDX, 32'h0);
    irq_req <= 1'b1;
    repeat (6) @(posedge clk);
    chk("pirq masked", 32'h0, 32'(irq));
    rdr(spx_pkg::ISTAT_IDX);
    chk("pirq sticky", 32'h2, rd);
    irq_req <= 1'b0;
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    rst = 1'b1;
    {psel, pen, pwr, irq_req, fall} = 5'h0;
    paddr = 14'h0;
    pwdata = 32'h0;
    stx = 32'hA5C3_5A3C;
    div = 20;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_frames;
    t_refused;
    t_manual;
    t_pirq;
    end_sim;
  end

  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    $display("watchdog expired");
    end_sim;
  end
endmodule

`default_nettype wire
